// ==== core/psq_pkg.sv ====
// package: constants, types and register map of the presence output sequencer
`default_nettype none
package psq_pkg;
    // -------------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VALUE = 8'h04;
    localparam logic [7:0] OFS_LEVEL = 8'h08;
    localparam logic [7:0] OFS_T_LIGHT = 8'h0c;
    localparam logic [7:0] OFS_T_A = 8'h10;
    localparam logic [7:0] OFS_T_B = 8'h14;
    localparam logic [7:0] OFS_T_C = 8'h18;
    localparam logic [7:0] OFS_T_CYC = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CTRL_FMT_BYTE = 0;
    localparam int CTRL_CYC_ON = 1;
    localparam int CTRL_CYC_OFF = 2;
    localparam int CTRL_THREE = 3;
    localparam int VAL_ON_PCT_LSB = 0;
    localparam int VAL_OFF_PCT_LSB = 8;
    localparam int VAL_ON_BIT = 16;
    localparam int VAL_OFF_BIT = 17;
    localparam int LVL_A_LSB = 0;
    localparam int LVL_B_LSB = 8;
    localparam int LVL_C_LSB = 16;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DATA_LSB = 8;

    // -------------------------------------------------------------------
    // reset values and limits (times in seconds, levels in percent)
    // -------------------------------------------------------------------
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] RST_ON_PCT = 7'h64;
    localparam logic [6:0] RST_OFF_PCT = 7'h00;
    localparam logic [6:0] RST_LVL_PCT = 7'h00;
    localparam logic RST_ON_BIT = 1'b1;
    localparam logic RST_OFF_BIT = 1'b0;
    localparam logic [15:0] RST_T_LIGHT = 16'h012c;
    localparam logic [15:0] MIN_T_LIGHT = 16'h000a;
    localparam logic [15:0] RST_T_STAGE = 16'h001e;
    localparam logic [15:0] MIN_T_STAGE = 16'h0005;
    localparam logic [15:0] RST_T_CYC = 16'h0000;
    localparam logic [14:0] CODE_SCALE = 15'h00ff;
    localparam logic [14:0] CODE_ROUND = 15'h0032;
    localparam logic [14:0] CODE_DIV = 15'h0064;

    // -------------------------------------------------------------------
    // timing: one second of pclk at 20 MHz
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;

    typedef enum logic [2:0] {
        PSQ_IDLE, PSQ_ON, PSQ_DELAY, PSQ_STG_A, PSQ_STG_B, PSQ_STG_C, PSQ_OFF
    } psq_state_e;

    typedef struct packed {
        logic fmt_byte;
        logic cyc_on;
        logic cyc_off;
        logic three;
        logic [6:0] on_pct;
        logic [6:0] off_pct;
        logic on_bit;
        logic off_bit;
        logic [6:0] lvl_a;
        logic [6:0] lvl_b;
        logic [6:0] lvl_c;
        logic [15:0] t_light;
        logic [15:0] t_a;
        logic [15:0] t_b;
        logic [15:0] t_c;
        logic [15:0] t_cyc;
    } psq_cfg_s;

    typedef struct packed {
        logic valid;
        logic is_byte;
        logic [7:0] data;
    } psq_tx_s;
endpackage
`default_nettype wire

// ==== core/psq_tick.sv ====
// module: restartable one-second timebase
`default_nettype none
module psq_tick #(
    parameter int CYCLES = psq_pkg::SEC_CYCLES
) (
    input wire logic pclk,     // system clock
    input wire logic presetn,  // async reset, active low
    input wire logic restart,  // start a fresh second
    output logic tick          // one-cycle pulse per second
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } psq_tick_s;

    psq_tick_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (restart) begin
            s_d.cnt = 32'h0;
        end else if (s_q.cnt >= 32'(CYCLES - 1)) begin
            s_d.cnt = 32'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule
`default_nettype wire

// ==== core/psq_top.sv ====
// module: movement channel output sequencer with apb configuration
//
// Function
// - every switching action leaves as a telegram on the one output object
// - control bit chooses 1-bit or 1-byte output format, 1-bit after reset
// - byte format sends a level from zero to full scale in percent
// - bit format sends only zero for off or one for on
// - percent maps to byte by rounded scaling, 100 to 255, 1 to 3
// - start of motion sends the switch-on value in the chosen format
// - cyclic switch-on repeats the on value while the light stays on
// - after the off sequence the switch-off value is sent, default zero
// - cyclic switch-off repeats the off value while off persists
// - one repetition period in seconds serves both on and off repeats
// - optional three-stage off inserts three timed levels before switch-off
// - three-stage mode enters stage A when the light-on time expires
// - A then B then C on dwell expiry, then switch-off after C
// - each stage dwell is 5 to 65535 seconds, 30 by default
// - each stage has its own level, sent on entry to that stage
// - light-on delay starts at motion end and restarts on new motion
//
// Local design decisions: the register offsets and the APB slave port.
`default_nettype none
module psq_top #(
    parameter int SEC_CYCLES = psq_pkg::SEC_CYCLES
) (
    input wire logic pclk,            // apb clock, 20 MHz
    input wire logic presetn,         // async reset, active low
    input wire logic psel,            // apb select
    input wire logic penable,         // apb access phase
    input wire logic pwrite,          // apb write
    input wire logic [7:0] paddr,     // apb byte address
    input wire logic [31:0] pwdata,   // apb write data
    output logic [31:0] prdata,       // apb read data
    output logic pready,              // apb ready
    output logic pslverr,             // apb error on unmapped address
    input wire logic motion_start,    // pulse: motion detected
    input wire logic motion_end,      // pulse: motion no longer detected
    output var psq_pkg::psq_tx_s tx   // telegram to the output object
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        psq_pkg::psq_state_e st;
        psq_pkg::psq_cfg_s cfg;
        logic [15:0] sec_cnt;
        logic [15:0] cyc_cnt;
        logic tick_clr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        psq_pkg::psq_tx_s tx;
    } psq_top_s;

    psq_top_s s_q, s_d;
    logic tick_raw;
    logic tick;

    psq_tick #(
        .CYCLES(SEC_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .restart(s_q.tick_clr),
        .tick(tick_raw)
    );
    // a tick already in flight when the timebase restarts belongs to the old second
    assign tick = tick_raw && !s_q.tick_clr;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [7:0] pct_to_code(input logic [6:0] pct);
        logic [14:0] p;
        logic [14:0] m;
        p = {8'h0, (pct > psq_pkg::PCT_FULL) ? psq_pkg::PCT_FULL : pct};
        m = p * psq_pkg::CODE_SCALE + psq_pkg::CODE_ROUND;
        m = m / psq_pkg::CODE_DIV;
        return m[7:0];
    endfunction

    // builds one telegram; a stage level in bit format is on unless zero
    function automatic psq_pkg::psq_tx_s make_tx(input logic fmt_byte,
                                                 input logic [6:0] pct,
                                                 input logic bitv);
        psq_pkg::psq_tx_s t;
        t.valid = 1'b1;
        t.is_byte = fmt_byte;
        if (fmt_byte) begin
            t.data = pct_to_code(pct);
        end else begin
            t.data = {7'h0, bitv};
        end
        return t;
    endfunction

    function automatic logic [15:0] clamp_min(input logic [15:0] v,
                                              input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            psq_pkg::OFS_CTRL, psq_pkg::OFS_VALUE, psq_pkg::OFS_LEVEL,
            psq_pkg::OFS_T_LIGHT, psq_pkg::OFS_T_A, psq_pkg::OFS_T_B,
            psq_pkg::OFS_T_C, psq_pkg::OFS_T_CYC, psq_pkg::OFS_STATUS: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    function automatic logic [31:0] read_reg(input psq_top_s s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            psq_pkg::OFS_CTRL: begin
                r[psq_pkg::CTRL_FMT_BYTE] = s.cfg.fmt_byte;
                r[psq_pkg::CTRL_CYC_ON] = s.cfg.cyc_on;
                r[psq_pkg::CTRL_CYC_OFF] = s.cfg.cyc_off;
                r[psq_pkg::CTRL_THREE] = s.cfg.three;
            end
            psq_pkg::OFS_VALUE: begin
                r[psq_pkg::VAL_ON_PCT_LSB +: 7] = s.cfg.on_pct;
                r[psq_pkg::VAL_OFF_PCT_LSB +: 7] = s.cfg.off_pct;
                r[psq_pkg::VAL_ON_BIT] = s.cfg.on_bit;
                r[psq_pkg::VAL_OFF_BIT] = s.cfg.off_bit;
            end
            psq_pkg::OFS_LEVEL: begin
                r[psq_pkg::LVL_A_LSB +: 7] = s.cfg.lvl_a;
                r[psq_pkg::LVL_B_LSB +: 7] = s.cfg.lvl_b;
                r[psq_pkg::LVL_C_LSB +: 7] = s.cfg.lvl_c;
            end
            psq_pkg::OFS_T_LIGHT: begin
                r[15:0] = s.cfg.t_light;
            end
            psq_pkg::OFS_T_A: begin
                r[15:0] = s.cfg.t_a;
            end
            psq_pkg::OFS_T_B: begin
                r[15:0] = s.cfg.t_b;
            end
            psq_pkg::OFS_T_C: begin
                r[15:0] = s.cfg.t_c;
            end
            psq_pkg::OFS_T_CYC: begin
                r[15:0] = s.cfg.t_cyc;
            end
            psq_pkg::OFS_STATUS: begin
                r[psq_pkg::STAT_STATE_LSB +: 3] = s.st;
                r[psq_pkg::STAT_DATA_LSB +: 8] = s.tx.data;
            end
            default: begin
                r = 32'h0;
            end
        endcase
        return r;
    endfunction

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic stage_done;
    logic cyc_due;
    logic light_on;
    logic access;
    logic commit;

    always_comb begin
        s_d = s_q;
        s_d.tx.valid = 1'b0;
        s_d.tick_clr = 1'b0;
        access = psel && penable;
        commit = access && s_q.pready;

        // apb: one wait state, write lands on the edge that sees pready
        s_d.pready = access && !s_q.pready;
        s_d.pslverr = access && !s_q.pready && !is_mapped(paddr);
        if (access && !s_q.pready && !pwrite) begin
            s_d.prdata = read_reg(s_q, paddr);
        end else begin
            s_d.prdata = 32'h0;
        end
        if (commit && pwrite) begin
            case (paddr)
                psq_pkg::OFS_CTRL: begin
                    s_d.cfg.fmt_byte = pwdata[psq_pkg::CTRL_FMT_BYTE];
                    s_d.cfg.cyc_on = pwdata[psq_pkg::CTRL_CYC_ON];
                    s_d.cfg.cyc_off = pwdata[psq_pkg::CTRL_CYC_OFF];
                    s_d.cfg.three = pwdata[psq_pkg::CTRL_THREE];
                end
                psq_pkg::OFS_VALUE: begin
                    s_d.cfg.on_pct = pwdata[psq_pkg::VAL_ON_PCT_LSB +: 7];
                    s_d.cfg.off_pct = pwdata[psq_pkg::VAL_OFF_PCT_LSB +: 7];
                    s_d.cfg.on_bit = pwdata[psq_pkg::VAL_ON_BIT];
                    s_d.cfg.off_bit = pwdata[psq_pkg::VAL_OFF_BIT];
                end
                psq_pkg::OFS_LEVEL: begin
                    s_d.cfg.lvl_a = pwdata[psq_pkg::LVL_A_LSB +: 7];
                    s_d.cfg.lvl_b = pwdata[psq_pkg::LVL_B_LSB +: 7];
                    s_d.cfg.lvl_c = pwdata[psq_pkg::LVL_C_LSB +: 7];
                end
                psq_pkg::OFS_T_LIGHT: begin
                    s_d.cfg.t_light = clamp_min(pwdata[15:0], psq_pkg::MIN_T_LIGHT);
                end
                psq_pkg::OFS_T_A: begin
                    s_d.cfg.t_a = clamp_min(pwdata[15:0], psq_pkg::MIN_T_STAGE);
                end
                psq_pkg::OFS_T_B: begin
                    s_d.cfg.t_b = clamp_min(pwdata[15:0], psq_pkg::MIN_T_STAGE);
                end
                psq_pkg::OFS_T_C: begin
                    s_d.cfg.t_c = clamp_min(pwdata[15:0], psq_pkg::MIN_T_STAGE);
                end
                psq_pkg::OFS_T_CYC: begin
                    s_d.cfg.t_cyc = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // second counters advance on the shared tick
        if (tick) begin
            s_d.sec_cnt = s_q.sec_cnt + 16'h1;
            s_d.cyc_cnt = s_q.cyc_cnt + 16'h1;
        end
        case (s_q.st)
            psq_pkg::PSQ_DELAY: begin
                stage_done = tick && (s_q.sec_cnt + 16'h1 >= s_q.cfg.t_light);
            end
            psq_pkg::PSQ_STG_A: begin
                stage_done = tick && (s_q.sec_cnt + 16'h1 >= s_q.cfg.t_a);
            end
            psq_pkg::PSQ_STG_B: begin
                stage_done = tick && (s_q.sec_cnt + 16'h1 >= s_q.cfg.t_b);
            end
            psq_pkg::PSQ_STG_C: begin
                stage_done = tick && (s_q.sec_cnt + 16'h1 >= s_q.cfg.t_c);
            end
            default: begin
                stage_done = 1'b0;
            end
        endcase
        // a zero period disables repetition rather than flooding the bus
        cyc_due = tick && (s_q.cfg.t_cyc != 16'h0)
                  && (s_q.cyc_cnt + 16'h1 >= s_q.cfg.t_cyc);
        light_on = (s_q.st == psq_pkg::PSQ_ON) || (s_q.st == psq_pkg::PSQ_DELAY);
        if (cyc_due) begin
            s_d.cyc_cnt = 16'h0;
        end

        // -------------------------------------------------------------------
        // sequencer
        // -------------------------------------------------------------------
        case (s_q.st)
            psq_pkg::PSQ_ON: begin
                if (motion_end) begin
                    s_d.st = psq_pkg::PSQ_DELAY;
                    s_d.sec_cnt = 16'h0;
                    s_d.tick_clr = 1'b1;
                end
            end
            psq_pkg::PSQ_DELAY: begin
                if (motion_start) begin
                    s_d.st = psq_pkg::PSQ_ON;
                    s_d.sec_cnt = 16'h0;
                end else if (stage_done && s_q.cfg.three) begin
                    s_d.st = psq_pkg::PSQ_STG_A;
                    s_d.sec_cnt = 16'h0;
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.lvl_a,
                                     s_q.cfg.lvl_a != 7'h0);
                end else if (stage_done) begin
                    s_d.st = psq_pkg::PSQ_OFF;
                    s_d.cyc_cnt = 16'h0;
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.off_pct, s_q.cfg.off_bit);
                end
            end
            psq_pkg::PSQ_STG_A: begin
                if (stage_done) begin
                    s_d.st = psq_pkg::PSQ_STG_B;
                    s_d.sec_cnt = 16'h0;
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.lvl_b,
                                     s_q.cfg.lvl_b != 7'h0);
                end
            end
            psq_pkg::PSQ_STG_B: begin
                if (stage_done) begin
                    s_d.st = psq_pkg::PSQ_STG_C;
                    s_d.sec_cnt = 16'h0;
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.lvl_c,
                                     s_q.cfg.lvl_c != 7'h0);
                end
            end
            psq_pkg::PSQ_STG_C: begin
                if (stage_done) begin
                    s_d.st = psq_pkg::PSQ_OFF;
                    s_d.cyc_cnt = 16'h0;
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.off_pct, s_q.cfg.off_bit);
                end
            end
            psq_pkg::PSQ_OFF: begin
                if (cyc_due && s_q.cfg.cyc_off) begin
                    s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.off_pct,
                                     s_q.cfg.off_bit);
                end
            end
            psq_pkg::PSQ_IDLE: begin
            end
            default: begin
                s_d.st = psq_pkg::PSQ_IDLE;
            end
        endcase

        // on-repeat runs through the light-on delay since the lamp is still lit
        if (light_on && cyc_due && s_q.cfg.cyc_on && !stage_done) begin
            s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.on_pct, s_q.cfg.on_bit);
        end

        // motion outside the lit states aborts any off stage and switches on
        if (motion_start && !light_on) begin
            s_d.st = psq_pkg::PSQ_ON;
            s_d.sec_cnt = 16'h0;
            s_d.cyc_cnt = 16'h0;
            s_d.tick_clr = 1'b1;
            s_d.tx = make_tx(s_q.cfg.fmt_byte, s_q.cfg.on_pct, s_q.cfg.on_bit);
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= psq_pkg::PSQ_IDLE;
            s_q.cfg.on_pct <= psq_pkg::RST_ON_PCT;
            s_q.cfg.off_pct <= psq_pkg::RST_OFF_PCT;
            s_q.cfg.on_bit <= psq_pkg::RST_ON_BIT;
            s_q.cfg.off_bit <= psq_pkg::RST_OFF_BIT;
            s_q.cfg.lvl_a <= psq_pkg::RST_LVL_PCT;
            s_q.cfg.lvl_b <= psq_pkg::RST_LVL_PCT;
            s_q.cfg.lvl_c <= psq_pkg::RST_LVL_PCT;
            s_q.cfg.t_light <= psq_pkg::RST_T_LIGHT;
            s_q.cfg.t_a <= psq_pkg::RST_T_STAGE;
            s_q.cfg.t_b <= psq_pkg::RST_T_STAGE;
            s_q.cfg.t_c <= psq_pkg::RST_T_STAGE;
            s_q.cfg.t_cyc <= psq_pkg::RST_T_CYC;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign tx = s_q.tx;
endmodule
`default_nettype wire

// ==== verification/psq_actuator.sv ====
// model: bus actuator that counts the telegrams it receives and keeps the last value
`default_nettype none
module psq_actuator (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire psq_pkg::psq_tx_s tx, // telegram from the sensor
    output logic [15:0] rx_count, // telegrams received
    output logic [7:0] rx_last // last value received
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_count <= 16'h0000;
            rx_last <= 8'h00;
        end else if (tx.valid) begin
            rx_count <= rx_count + 16'h0001;
            rx_last <= tx.data;
        end
    end
endmodule
`default_nettype wire

// ==== verification/psq_top_checker.sv ====
// checker: apb handshake and telegram relations of the sequencer
`default_nettype none
module psq_top_checker #(
    parameter int SEC_CYCLES = 10
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic motion_start, // motion begins
    input wire logic motion_end, // motion ends
    input wire psq_pkg::psq_tx_s tx // telegram
);
    // shadow of the format bit, so telegrams are judged without the bodies
    logic fmt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == psq_pkg::OFS_CTRL) begin
            fmt_q <= pwdata[psq_pkg::CTRL_FMT_BYTE];
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no wait state answer");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    chk_err_unmapped: assert property (psel && penable && !pready && paddr > 8'h20 |=> pslverr)
        else $error("unmapped not refused");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    chk_bit_value: assert property (tx.valid && !tx.is_byte |-> tx.data[7:1] == 7'h00)
        else $error("bit telegram not 0 or 1");
    chk_fmt_match: assert property (tx.valid |-> tx.is_byte == fmt_q)
        else $error("telegram format wrong");
    chk_tx_pulse: assert property (tx.valid |=> !tx.valid)
        else $error("telegram valid held");
    chk_tx_hold: assert property (!tx.valid |-> $stable(tx.data))
        else $error("telegram data moved");
endmodule
bind psq_top psq_top_checker #(.SEC_CYCLES(SEC_CYCLES)) psq_top_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motion_start(motion_start), .motion_end(motion_end), .tx(tx));
`default_nettype wire

// ==== verification/psq_top_bench.sv ====
// bench: apb setup and motion sequences of the output sequencer
`default_nettype none
module psq_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, motion_start, motion_end, pready, pslverr;
    logic [7:0] paddr;
    logic [7:0] rx_last;
    logic [15:0] rx_count;
    logic [31:0] pwdata, prdata;
    logic [31:0] rst_val [8] = '{32'h0, 32'h10064, 32'h0, 32'h12c, 32'h1e, 32'h1e, 32'h1e, 32'h0};
    psq_pkg::psq_tx_s tx;
    int err_count, check_count, cyc, tx_seen;
    // ten clocks a second keeps the minute-long waits short
    psq_top #(.SEC_CYCLES(10)) psq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .motion_start(motion_start),
        .motion_end(motion_end), .tx(tx));
    psq_actuator psq_actuator_inst (.pclk(pclk), .presetn(presetn), .tx(tx),
        .rx_count(rx_count), .rx_last(rx_last));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one idle cycle after each transfer so psel never changes twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check($sformatf("read %h", a), exp, r);
        check("pslverr", {31'h0, exp_e}, {31'h0, e});
    endtask
    task automatic pulse(input logic st);
        motion_start <= st;
        motion_end <= !st;
        @(posedge pclk);
        motion_start <= 1'b0;
        motion_end <= 1'b0;
    endtask
    task automatic wait_tx(input logic [7:0] exp, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tx.valid !== 1'b1);
        tx_seen++;
        check("tx data", {24'h0, exp}, {24'h0, tx.data});
        check($sformatf("tx gap %0d", n), 32'h1, {31'h0, (n >= lo && n <= hi)});
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, motion_start, motion_end, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), rst_val[i], 1'b0);
        rd(8'h24, 32'h0, 1'b1);
        wr(8'h0c, 32'h5);
        rd(8'h0c, 32'h0a, 1'b0);
        pulse(1'b1);
        wait_tx(8'h01, 1, 2);
        pulse(1'b0);
        repeat (50) @(posedge pclk);
        pulse(1'b1);
        pulse(1'b0);
        wait_tx(8'h00, 95, 106);
        wr(8'h00, 32'h9);
        wr(8'h04, 32'h64);
        wr(8'h08, 32'h11432);
        wr(8'h10, 32'h2);
        rd(8'h10, 32'h5, 1'b0);
        wr(8'h18, 32'h6);
        wr(8'h14, 32'h5);
        pulse(1'b1);
        wait_tx(8'hff, 1, 2);
        pulse(1'b0);
        wait_tx(8'h80, 95, 106);
        wait_tx(8'h33, 45, 56);
        wr(8'h00, 32'hb);
        wr(8'h1c, 32'h3);
        pulse(1'b1);
        wait_tx(8'hff, 1, 2);
        wait_tx(8'hff, 25, 36);
        wait_tx(8'hff, 25, 36);
        wr(8'h00, 32'hd);
        pulse(1'b0);
        wait_tx(8'h80, 95, 106);
        wait_tx(8'h33, 45, 56);
        wait_tx(8'h03, 45, 56);
        wait_tx(8'h00, 55, 66);
        wait_tx(8'h00, 25, 36);
        // the actuator takes the last telegram on the edge wait_tx returned at
        @(posedge pclk);
        check("rx count", 32'(tx_seen), {16'h0, rx_count});
        check("rx last", 32'h0, {24'h0, rx_last});
        rd(8'h20, 32'h6, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
